/* rtl/lin_irq_wakeup_ctrl_defines.svh */
// Function
// R01: two interrupt lines, each fed by its own priority encoder.
// R02: per-source enable, set via enable-set write, cleared via enable-clear write.
// R03: sources start on line 0; level-set moves to line 1, level-clear back.
// R04: vector register returns highest-priority pending enabled source of that line.
// R05: software disables and re-enables interrupts to see remaining pending sources.
// R06: offsets 0 none, 1 wakeup ... 16 bus idle; 1 highest priority.
// R07: nine sources only in LIN mode, break detect only in plain serial mode.
// R08: three timeout sources: 150 ms after wakeup, three wakeups, 4 s idle.
// R09: power-down bit 0 of control 2 stops internal clocks; clearing resumes.
// R10: registers stay reachable in power-down; each access enables clock briefly.
// R11: software sets power-down after receiving the sleep command frame.
// R12: power-down during reception with wakeup enabled: raise wakeup, cancel power-down.
// R13: power-down during reception with wakeup disabled: finish reception, then sleep.
// R14: powered down with wakeup enabled, low receive pin raises wakeup, clears power-down.
// R15: with wakeup disabled, low receive pin does not leave low power.
// R16: no wakeup interrupt from a pulse while not powered down.
// R17: wake generate sends transmit byte 0, regardless of transmit enable.
// R18: wake pulse holds bus dominant at least five bit times.
// R19: wake generate writable only in soft reset release and power-down; cleared by break/reset.
// R20: no sync within 150 ms after pulse end sends another pulse.
// R21: after three unanswered attempts, suspend wake generation for 1.5 s.
// R22: in debug suspend counters run when free-run bit set, halt otherwise.
// R23: reads in emulation mode have no side effect on flags.
// R24: each line stays high while an enabled pending flag maps to it.
`ifndef LIN_IRQ_WAKEUP_CTRL_DEFINES_SVH
`define LIN_IRQ_WAKEUP_CTRL_DEFINES_SVH

// register byte offsets
`define OFS_GLOBAL_CONTROL_1   12'h000
`define OFS_GLOBAL_CONTROL_2   12'h004
`define OFS_IRQ_ENABLE_SET     12'h008
`define OFS_IRQ_ENABLE_CLEAR   12'h00c
`define OFS_IRQ_LINE_SET       12'h010
`define OFS_IRQ_LINE_CLEAR     12'h014
`define OFS_FLAG_REGISTER      12'h018
`define OFS_LINE0_VECTOR       12'h01c
`define OFS_LINE1_VECTOR       12'h020
`define OFS_TX_BUFFER_BYTE0    12'h024
`define OFS_WAKE_PRESCALER     12'h028

// field positions
`define BIT_LIN_MODE           6
`define BIT_SOFT_RESET_RELEASE 7
`define BIT_DEBUG_FREE_RUN     17
`define BIT_POWER_DOWN         0
`define BIT_WAKE_GENERATE      8

// source masks, bit n is offset n+1
`define MASK_LIN_ONLY          16'hf29a
`define MASK_SERIAL_ONLY       16'h0040
`define SRC_WAKEUP             0
`define SRC_TO_WAKE            13
`define SRC_TO_THREE           14
`define SRC_TO_IDLE            15

// reset values
`define RST_TX_BYTE0           8'hf0
`define RST_WAKE_PRESCALER     16'h09c4

// timing
`define CLK_MHZ                50
`define WAKE_RETRY_US          150000
`define WAKE_SUSPEND_US        1500000
`define BUS_IDLE_US            4000000
`define WAKE_ATTEMPTS          2'd3

`endif

/* rtl/lin_irq_wakeup_pkg.sv */
package lin_irq_wakeup_pkg;
  typedef enum logic [1:0] {
    WAKE_IDLE,
    WAKE_SEND,
    WAKE_WAIT,
    WAKE_SUSPEND
  } wake_state_e;
  typedef logic [4:0] vector_t;
endpackage : lin_irq_wakeup_pkg

/* rtl/wake_byte_tx.sv */
`timescale 1ns/1ps
`default_nettype none
module wake_byte_tx (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        run_i,
  input  wire logic        start_i,
  input  wire logic [7:0]  byte_i,
  input  wire logic [15:0] bit_cyc_i,
  output logic             tx_o,
  output logic             busy_o,
  output logic             done_o
);
  logic [9:0]  shift_q;
  logic [3:0]  bits_q;
  logic [15:0] cnt_q;
  logic [15:0] bit_len;

  // zero prescaler would give no bit time at all
  assign bit_len = (bit_cyc_i == 16'h0000) ? 16'h0001 : bit_cyc_i;
  assign busy_o  = (bits_q != 4'h0);

  // start bit, eight data bits lsb first, stop bit; 0xf0 gives five dominant bits
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_q <= 10'h3ff;
      bits_q  <= 4'h0;
      cnt_q   <= 16'h0000;
      tx_o    <= 1'b1;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        shift_q <= {1'b1, byte_i, 1'b0}; // R17
        bits_q  <= 4'ha;
        cnt_q   <= 16'h0000;
        tx_o    <= 1'b0;
      end else if (busy_o && run_i) begin
        if (cnt_q == bit_len - 16'h0001) begin // R18
          cnt_q   <= 16'h0000;
          shift_q <= {1'b1, shift_q[9:1]};
          bits_q  <= bits_q - 4'h1;
          tx_o    <= (bits_q == 4'h1) ? 1'b1 : shift_q[1];
          done_o  <= (bits_q == 4'h1);
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end
    end
  end
endmodule : wake_byte_tx
`default_nettype wire

/* rtl/lin_irq_wakeup_ctrl.sv */
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "lin_irq_wakeup_ctrl_defines.svh"
module lin_irq_wakeup_ctrl #(
  parameter int unsigned RETRY_CYC   = `WAKE_RETRY_US * `CLK_MHZ,
  parameter int unsigned SUSPEND_CYC = `WAKE_SUSPEND_US * `CLK_MHZ,
  parameter int unsigned IDLE_CYC    = `BUS_IDLE_US * `CLK_MHZ
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [15:0] src_event_i,
  input  wire logic        rx_busy_i,
  input  wire logic        sync_break_i,
  input  wire logic        sync_field_i,
  input  wire logic        debug_suspend_i,
  input  wire logic        bus_receive_pin_i,
  output logic             bus_transmit_o,
  output logic             irq_line_low_o,
  output logic             irq_line_high_o,
  output logic             module_clk_en_o,
  output logic             powered_down_o
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (RETRY_CYC < 1 || SUSPEND_CYC < 1 || IDLE_CYC < 1) begin : g_chk
    $error("timeout counts must be at least one cycle");
  end

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [15:0] enable_q;
  logic [15:0] line_sel_q;
  logic [15:0] flag_q;
  logic [15:0] flag_set;
  logic [15:0] flag_clr;
  logic [15:0] mode_mask;
  logic        lin_mode_q;
  logic        soft_reset_release_q;
  logic        debug_free_run_q;
  logic        power_down_q;
  logic        pd_pending_q;
  logic        wake_gen_q;
  logic [7:0]  tx_byte0_q;
  logic [15:0] prescaler_q;
  logic [31:0] prdata_q;
  logic        pin_meta_q;
  logic        pin_sync_q;
  logic        counters_run;
  logic        setup_phase;
  logic        access_phase;
  logic        wr_access;
  logic        rd_access;
  logic        addr_hit;
  logic        pd_write;
  logic        pd_request;
  logic        wake_trigger;
  logic        early_wake;
  logic [15:0] line0_pend;
  logic [15:0] line1_pend;
  lin_irq_wakeup_pkg::vector_t vec0;
  lin_irq_wakeup_pkg::vector_t vec1;
  lin_irq_wakeup_pkg::wake_state_e wake_state_q;
  logic [1:0]  attempts_q;
  logic [31:0] wake_cnt_q;
  logic [31:0] idle_cnt_q;
  logic        tx_start;
  logic        tx_busy;
  logic        tx_done;
  logic        retry_expired;
  logic        suspend_expired;
  logic        idle_expired;

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  // lowest flag index wins, offset is index plus one
  function automatic lin_irq_wakeup_pkg::vector_t prio_encode(input logic [15:0] pend);
    lin_irq_wakeup_pkg::vector_t v;
    v = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (pend[i]) begin
        v = 5'(i + 1);
      end
    end
    return v;
  endfunction : prio_encode

  function automatic logic [15:0] offset_onehot(input lin_irq_wakeup_pkg::vector_t v);
    logic [15:0] m;
    m = 16'h0000;
    if (v != 5'h00) begin
      m[4'(v - 5'h01)] = 1'b1;
    end
    return m;
  endfunction : offset_onehot

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  assign setup_phase  = psel_i && !penable_i;
  assign access_phase = psel_i && penable_i;
  assign wr_access    = access_phase && pwrite_i && addr_hit;
  assign rd_access    = access_phase && !pwrite_i && addr_hit;
  assign pready_o     = 1'b1;
  assign pslverr_o    = access_phase && !addr_hit;
  assign prdata_o     = prdata_q;

  always_comb begin
    unique case (paddr_i)
      `OFS_GLOBAL_CONTROL_1,
      `OFS_GLOBAL_CONTROL_2,
      `OFS_IRQ_ENABLE_SET,
      `OFS_IRQ_ENABLE_CLEAR,
      `OFS_IRQ_LINE_SET,
      `OFS_IRQ_LINE_CLEAR,
      `OFS_FLAG_REGISTER,
      `OFS_LINE0_VECTOR,
      `OFS_LINE1_VECTOR,
      `OFS_TX_BUFFER_BYTE0,
      `OFS_WAKE_PRESCALER: addr_hit = 1'b1;
      default:             addr_hit = 1'b0;
    endcase
  end

  // read data captured in setup so it is stable through the access phase
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_phase && !pwrite_i) begin
      unique case (paddr_i)
        `OFS_GLOBAL_CONTROL_1: prdata_q <= (32'(debug_free_run_q) << `BIT_DEBUG_FREE_RUN)
                                         | (32'(soft_reset_release_q) << `BIT_SOFT_RESET_RELEASE)
                                         | (32'(lin_mode_q) << `BIT_LIN_MODE);
        `OFS_GLOBAL_CONTROL_2: prdata_q <= (32'(wake_gen_q) << `BIT_WAKE_GENERATE)
                                         | (32'(power_down_q) << `BIT_POWER_DOWN);
        `OFS_IRQ_ENABLE_SET,
        `OFS_IRQ_ENABLE_CLEAR: prdata_q <= {16'h0000, enable_q};
        `OFS_IRQ_LINE_SET,
        `OFS_IRQ_LINE_CLEAR:   prdata_q <= {16'h0000, line_sel_q};
        `OFS_FLAG_REGISTER:    prdata_q <= {16'h0000, flag_q};
        `OFS_LINE0_VECTOR:     prdata_q <= {27'h0000000, vec0}; // R04
        `OFS_LINE1_VECTOR:     prdata_q <= {27'h0000000, vec1}; // R04
        `OFS_TX_BUFFER_BYTE0:  prdata_q <= {24'h000000, tx_byte0_q};
        `OFS_WAKE_PRESCALER:   prdata_q <= {16'h0000, prescaler_q};
        default:               prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // clock gating and counter run
  // ------------------------------------------------------------
  // the functional clock of the protocol engine is gated outside this block
  assign module_clk_en_o = !power_down_q || psel_i; // R09 R10
  assign powered_down_o  = power_down_q;
  assign counters_run    = !debug_suspend_i || debug_free_run_q; // R22

  // ------------------------------------------------------------
  // receive pin synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
    end else begin
      pin_meta_q <= bus_receive_pin_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lin_mode_q           <= 1'b0;
      soft_reset_release_q <= 1'b0;
      debug_free_run_q     <= 1'b0;
      tx_byte0_q           <= `RST_TX_BYTE0;
      prescaler_q          <= `RST_WAKE_PRESCALER;
    end else if (wr_access) begin
      if (paddr_i == `OFS_GLOBAL_CONTROL_1) begin
        lin_mode_q           <= pwdata_i[`BIT_LIN_MODE];
        soft_reset_release_q <= pwdata_i[`BIT_SOFT_RESET_RELEASE];
        debug_free_run_q     <= pwdata_i[`BIT_DEBUG_FREE_RUN];
      end
      if (paddr_i == `OFS_TX_BUFFER_BYTE0) begin
        tx_byte0_q <= pwdata_i[7:0];
      end
      if (paddr_i == `OFS_WAKE_PRESCALER) begin
        prescaler_q <= pwdata_i[15:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enable_q <= 16'h0000;
    end else if (wr_access && paddr_i == `OFS_IRQ_ENABLE_SET) begin
      enable_q <= enable_q | pwdata_i[15:0]; // R02
    end else if (wr_access && paddr_i == `OFS_IRQ_ENABLE_CLEAR) begin
      enable_q <= enable_q & ~pwdata_i[15:0]; // R02
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_sel_q <= 16'h0000; // R03
    end else if (wr_access && paddr_i == `OFS_IRQ_LINE_SET) begin
      line_sel_q <= line_sel_q | pwdata_i[15:0]; // R03
    end else if (wr_access && paddr_i == `OFS_IRQ_LINE_CLEAR) begin
      line_sel_q <= line_sel_q & ~pwdata_i[15:0]; // R03
    end
  end

  // ------------------------------------------------------------
  // power-down and wakeup detection
  // ------------------------------------------------------------
  assign pd_write     = wr_access && paddr_i == `OFS_GLOBAL_CONTROL_2;
  assign pd_request   = pd_write && pwdata_i[`BIT_POWER_DOWN];
  assign early_wake   = pd_request && rx_busy_i && enable_q[`SRC_WAKEUP]; // R12
  // only a sleeping module may wake; a pulse seen while awake is ignored
  assign wake_trigger = power_down_q && enable_q[`SRC_WAKEUP] && !pin_sync_q; // R14 R15 R16

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      power_down_q <= 1'b0;
      pd_pending_q <= 1'b0;
    end else begin
      if (pd_write && !pwdata_i[`BIT_POWER_DOWN]) begin
        power_down_q <= 1'b0; // R09
        pd_pending_q <= 1'b0;
      end else if (early_wake) begin
        power_down_q <= 1'b0; // R12
        pd_pending_q <= 1'b0;
      end else if (pd_request && rx_busy_i) begin
        pd_pending_q <= 1'b1; // R13
      end else if (pd_request) begin
        power_down_q <= 1'b1; // R09
      end else if (pd_pending_q && !rx_busy_i) begin
        power_down_q <= 1'b1; // R13
        pd_pending_q <= 1'b0;
      end else if (wake_trigger) begin
        power_down_q <= 1'b0; // R14
      end
    end
  end

  // write attempts outside the allowed window are dropped
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_gen_q <= 1'b0;
    end else if (!soft_reset_release_q || sync_break_i) begin
      wake_gen_q <= 1'b0; // R19
    end else if (pd_write && power_down_q) begin
      wake_gen_q <= pwdata_i[`BIT_WAKE_GENERATE]; // R19
    end
  end

  // ------------------------------------------------------------
  // wakeup pulse generation and retry timeouts
  // ------------------------------------------------------------
  assign retry_expired   = (wake_cnt_q == RETRY_CYC - 1);
  assign suspend_expired = (wake_cnt_q == SUSPEND_CYC - 1);
  assign tx_start        = counters_run && wake_gen_q && !tx_busy
                         && ((wake_state_q == lin_irq_wakeup_pkg::WAKE_IDLE)
                         || (wake_state_q == lin_irq_wakeup_pkg::WAKE_WAIT
                         && retry_expired && attempts_q != `WAKE_ATTEMPTS)); // R17 R20

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_state_q <= lin_irq_wakeup_pkg::WAKE_IDLE;
      attempts_q   <= 2'd0;
      wake_cnt_q   <= 32'h0000_0000;
    end else if (counters_run) begin // R22
      unique case (wake_state_q)
        lin_irq_wakeup_pkg::WAKE_IDLE: begin
          wake_cnt_q <= 32'h0000_0000;
          if (tx_start) begin
            wake_state_q <= lin_irq_wakeup_pkg::WAKE_SEND;
            attempts_q   <= 2'd1;
          end
        end
        lin_irq_wakeup_pkg::WAKE_SEND: begin
          // retry time runs from the end of the dominant part, not of the byte
          wake_cnt_q <= bus_transmit_o ? wake_cnt_q + 32'h0000_0001 : 32'h0000_0000; // R20
          if (tx_done) begin
            wake_state_q <= lin_irq_wakeup_pkg::WAKE_WAIT;
          end
        end
        lin_irq_wakeup_pkg::WAKE_WAIT: begin
          if (sync_field_i || !wake_gen_q) begin
            wake_state_q <= lin_irq_wakeup_pkg::WAKE_IDLE;
            attempts_q   <= 2'd0;
          end else if (retry_expired) begin
            wake_cnt_q <= 32'h0000_0000;
            if (attempts_q == `WAKE_ATTEMPTS) begin
              wake_state_q <= lin_irq_wakeup_pkg::WAKE_SUSPEND; // R21
            end else begin
              wake_state_q <= lin_irq_wakeup_pkg::WAKE_SEND; // R20
              attempts_q   <= attempts_q + 2'd1;
            end
          end else begin
            wake_cnt_q <= wake_cnt_q + 32'h0000_0001;
          end
        end
        lin_irq_wakeup_pkg::WAKE_SUSPEND: begin
          if (suspend_expired || !wake_gen_q) begin
            wake_state_q <= lin_irq_wakeup_pkg::WAKE_IDLE; // R21
            attempts_q   <= 2'd0;
            wake_cnt_q   <= 32'h0000_0000;
          end else begin
            wake_cnt_q <= wake_cnt_q + 32'h0000_0001;
          end
        end
      endcase
    end
  end

  wake_byte_tx u_wake_tx (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .run_i     (counters_run),
    .start_i   (tx_start),
    .byte_i    (tx_byte0_q),
    .bit_cyc_i (prescaler_q),
    .tx_o      (bus_transmit_o),
    .busy_o    (tx_busy),
    .done_o    (tx_done)
  );

  // ------------------------------------------------------------
  // bus idle timeout
  // ------------------------------------------------------------
  assign idle_expired = (idle_cnt_q == IDLE_CYC - 1);

  // counter saturates past the mark so one idle period gives one event
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle_cnt_q <= 32'h0000_0000;
    end else if (!pin_sync_q || !lin_mode_q) begin
      idle_cnt_q <= 32'h0000_0000;
    end else if (counters_run && idle_cnt_q != IDLE_CYC) begin // R22
      idle_cnt_q <= idle_cnt_q + 32'h0000_0001; // R08
    end
  end

  // ------------------------------------------------------------
  // flags and priority encoders
  // ------------------------------------------------------------
  assign mode_mask = lin_mode_q ? ~`MASK_SERIAL_ONLY : ~`MASK_LIN_ONLY; // R07

  always_comb begin
    flag_set = src_event_i;
    flag_set[`SRC_WAKEUP]   = wake_trigger || early_wake; // R12 R14
    flag_set[`SRC_TO_WAKE]  = counters_run && wake_state_q == lin_irq_wakeup_pkg::WAKE_WAIT
                            && retry_expired && !sync_field_i && wake_gen_q; // R08
    flag_set[`SRC_TO_THREE] = flag_set[`SRC_TO_WAKE] && attempts_q == `WAKE_ATTEMPTS; // R08
    flag_set[`SRC_TO_IDLE]  = counters_run && idle_expired && pin_sync_q; // R08
    flag_set = flag_set & mode_mask; // R07
  end

  // a vector read acknowledges the source it reports, except in emulation
  always_comb begin
    flag_clr = 16'h0000;
    if (wr_access && paddr_i == `OFS_FLAG_REGISTER) begin
      flag_clr = pwdata_i[15:0];
    end
    if (rd_access && !debug_suspend_i) begin // R23
      if (paddr_i == `OFS_LINE0_VECTOR) begin
        flag_clr = flag_clr | offset_onehot(vec0);
      end
      if (paddr_i == `OFS_LINE1_VECTOR) begin
        flag_clr = flag_clr | offset_onehot(vec1);
      end
    end
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_q <= 16'h0000;
    end else begin
      flag_q <= (flag_q & ~flag_clr) | flag_set;
    end
  end

  assign line0_pend = flag_q & enable_q & ~line_sel_q; // R01 R03
  assign line1_pend = flag_q & enable_q & line_sel_q;  // R01 R03
  assign vec0       = prio_encode(line0_pend); // R04 R06
  assign vec1       = prio_encode(line1_pend); // R04 R06

  // lines are registered so no decode glitch reaches the expander
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_line_low_o  <= 1'b0;
      irq_line_high_o <= 1'b0;
    end else begin
      irq_line_low_o  <= |line0_pend; // R24
      irq_line_high_o <= |line1_pend; // R24
    end
  end

endmodule : lin_irq_wakeup_ctrl
`default_nettype wire

/* rtl/placeholder_unused.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* tb/lin_irq_wakeup_ctrl_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module lin_irq_wakeup_ctrl_sva (
  input wire logic        clk_i, nrst_i, psel_i, penable_i, pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o, pslverr_o, rx_busy_i, debug_suspend_i,
  input wire logic        bus_receive_pin_i, bus_transmit_o,
  input wire logic        module_clk_en_o, powered_down_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire logic acc = psel_i && penable_i;
  wire logic wr  = acc && pwrite_i;
  wire logic pdw = wr && paddr_i == 12'h004;
  logic      run_q;
  // shadow of the free-run bit, only what the ports reveal
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) run_q <= 1'b0;
    else if (wr && paddr_i == 12'h000) run_q <= pwdata_i[17];
  end
  property p_err; pslverr_o |-> acc; endproperty
  a_err: assert property (p_err) else $error("slave error outside access");
  property p_rdy; acc |-> pready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("access not answered");
  property p_clk; module_clk_en_o == (!powered_down_o || psel_i); endproperty
  a_clk: assert property (p_clk) else $error("clock enable wrong");
  property p_busy; $rose(powered_down_o) |-> !$past(rx_busy_i); endproperty
  a_busy: assert property (p_busy) else $error("sleep during reception");
  property p_cancel; pdw && pwdata_i[0] && rx_busy_i && !powered_down_o |=> !powered_down_o;
  endproperty
  a_cancel: assert property (p_cancel) else $error("sleep not held off");
  property p_wake; $fell(powered_down_o) |-> $past(pdw && (!pwdata_i[0] || rx_busy_i))
    || !$past(bus_receive_pin_i, 2) || !$past(bus_receive_pin_i, 3)
    || !$past(bus_receive_pin_i, 4); endproperty
  a_wake: assert property (p_wake) else $error("power-down left without cause");
  property p_pulse; $fell(bus_transmit_o) |-> !bus_transmit_o [*5]; endproperty
  a_pulse: assert property (p_pulse) else $error("dominant pulse too short");
  property p_halt; $past(debug_suspend_i) && !$past(run_q) |-> $stable(bus_transmit_o); endproperty
  a_halt: assert property (p_halt) else $error("transmit moved while halted");
endmodule : lin_irq_wakeup_ctrl_sva
bind lin_irq_wakeup_ctrl lin_irq_wakeup_ctrl_sva u_sva (.clk_i, .nrst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .rx_busy_i,
  .debug_suspend_i, .bus_receive_pin_i, .bus_transmit_o, .module_clk_en_o, .powered_down_o);
`default_nettype wire

/* tb/lin_xcvr_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lin_xcvr_model (
  input  wire logic tx_i,
  input  wire logic wake_i,
  output logic      rx_o
);
  // bus pulled recessive; any dominant party wins, own transmit echoes back
  assign rx_o = tx_i & ~wake_i;
endmodule : lin_xcvr_model
`default_nettype wire

/* tb/lin_irq_wakeup_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, b); end end
module lin_irq_wakeup_ctrl_tb;
  logic clk_i = 0, nrst_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, wake = 0;
  logic rx_busy_i = 0, sync_break_i = 0, sync_field_i = 0, debug_suspend_i = 0;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, rd;
  logic [15:0] src_event_i = 0;
  logic pready_o, pslverr_o, bus_receive_pin_i, bus_transmit_o, er;
  logic irq_line_low_o, irq_line_high_o, module_clk_en_o, powered_down_o;
  int   err_total = 0, tests_run = 0, n;
  initial forever #10 clk_i = ~clk_i;
  // short counts so retry and suspend fit in the run
  lin_irq_wakeup_ctrl #(.RETRY_CYC(50), .SUSPEND_CYC(100), .IDLE_CYC(200)) u_dut (.*);
  lin_xcvr_model u_xcvr (.tx_i(bus_transmit_o), .wake_i(wake), .rx_o(bus_receive_pin_i));
  task automatic tick(input int k); repeat (k) @(posedge clk_i); endtask : tick
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i); psel_i <= 1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge clk_i); penable_i <= 1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o; er = pslverr_o; psel_i <= 0; penable_i <= 0;
  endtask : apb
  task automatic ev(input logic [15:0] m); src_event_i <= m; tick(1); src_event_i <= 0;
  endtask : ev
  task automatic pin_low; wake <= 1; tick(4); wake <= 0; tick(4); endtask : pin_low
  task automatic t_regs;
    apb(0, 12'h004, 0); `CHK(rd, 32'h0)
    apb(0, 12'h024, 0); `CHK(rd[7:0], 8'hf0)
    apb(0, 12'h008, 0); `CHK(rd[15:0], 16'h0)
    apb(0, 12'hffc, 0); `CHK(er, 1'b1)
    $display("regs done");
  endtask : t_regs
  task automatic t_prio;
    apb(1, 12'h000, 32'hc0); apb(1, 12'h008, 32'h0145);
    ev(16'h0144); tick(2);
    apb(0, 12'h018, 0); `CHK(rd[8:0], 9'h104)
    `CHK(irq_line_low_o, 1'b1)
    apb(1, 12'h010, 32'h100); tick(2); `CHK(irq_line_high_o, 1'b1)
    apb(0, 12'h020, 0); `CHK(rd[4:0], 5'd9)
    apb(0, 12'h01c, 0); `CHK(rd[4:0], 5'd3)
    tick(2); `CHK({irq_line_high_o, irq_line_low_o}, 2'b00)
    apb(1, 12'h014, 32'h100); apb(1, 12'h00c, 32'h0144);
    apb(0, 12'h008, 0); `CHK(rd[15:0], 16'h0001)
    apb(1, 12'h000, 32'h80); ev(16'h0040); tick(2);
    apb(0, 12'h018, 0); `CHK(rd[6], 1'b1)
    apb(1, 12'h018, 32'hffff); $display("prio done");
  endtask : t_prio
  task automatic t_pd;
    apb(1, 12'h00c, 1); apb(1, 12'h004, 1); tick(1); `CHK(powered_down_o, 1'b1)
    apb(0, 12'h004, 0); `CHK(rd[0], 1'b1)
    pin_low(); `CHK(powered_down_o, 1'b1)
    apb(1, 12'h008, 1); pin_low(); `CHK(powered_down_o, 1'b0)
    apb(0, 12'h01c, 0); `CHK(rd[4:0], 5'd1)
    pin_low(); apb(0, 12'h018, 0); `CHK(rd[0], 1'b0)
    $display("power-down done");
  endtask : t_pd
  task automatic t_busy;
    rx_busy_i <= 1; apb(1, 12'h004, 1); tick(2); `CHK(powered_down_o, 1'b0)
    apb(0, 12'h01c, 0); `CHK(rd[4:0], 5'd1)
    apb(1, 12'h00c, 1); apb(1, 12'h004, 1); tick(2); `CHK(powered_down_o, 1'b0)
    rx_busy_i <= 0; tick(2); `CHK(powered_down_o, 1'b1)
    apb(1, 12'h004, 0); $display("busy done");
  endtask : t_busy
  task automatic t_wake;
    apb(1, 12'h000, 32'hc0); apb(1, 12'h028, 2); apb(1, 12'h018, 32'hffff);
    apb(1, 12'h004, 32'h100); apb(0, 12'h004, 0); `CHK(rd[8], 1'b0)
    apb(1, 12'h004, 1); apb(1, 12'h004, 32'h101);
    n = 0; while (bus_transmit_o !== 1'b0 && n < 99) begin tick(1); n++; end
    n = 0; while (bus_transmit_o === 1'b0 && n < 99) begin tick(1); n++; end
    `CHK(n, 10)
    apb(0, 12'h004, 0); `CHK(rd[8], 1'b1)
    n = 0; while (bus_transmit_o !== 1'b0 && n < 200) begin tick(1); n++; end
    `CHK(bus_transmit_o, 1'b0)
    apb(0, 12'h018, 0); `CHK(rd[13], 1'b1)
    tick(250); apb(0, 12'h018, 0); `CHK(rd[14], 1'b1)
    sync_break_i <= 1; tick(1); sync_break_i <= 0; tick(1);
    apb(0, 12'h004, 0); `CHK(rd[8], 1'b0)
    apb(1, 12'h004, 0); apb(1, 12'h018, 32'hffff); $display("wake done");
  endtask : t_wake
  task automatic t_dbg;
    apb(1, 12'h008, 32'h4); debug_suspend_i <= 1; ev(16'h4); tick(1);
    apb(0, 12'h01c, 0); apb(0, 12'h01c, 0); `CHK(rd[4:0], 5'd3)
    debug_suspend_i <= 0; apb(0, 12'h01c, 0); `CHK(rd[4:0], 5'd3)
    apb(0, 12'h01c, 0); `CHK(rd[4:0], 5'd0)
    tick(210); apb(0, 12'h018, 0); `CHK(rd[15], 1'b1)
    $display("debug done");
  endtask : t_dbg
  task automatic end_sim;
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  initial begin
    #200000; err_total++; end_sim();
  end
  initial begin
    tick(4); nrst_i <= 1;
    t_regs(); t_prio(); t_pd(); t_busy(); t_wake(); t_dbg();
    end_sim();
  end
endmodule : lin_irq_wakeup_ctrl_tb
`default_nettype wire
